//--- include/sls_pkg.sv
package sls_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned OPERATION_READY_LAMP_DELAY_S    = 15;  // Front operation lamp delay
  localparam int unsigned BOOT_STEADY_S   = 12;  // Inside 10 - 15 s
  localparam int unsigned BOOT_FLASH_S    = 7;   // Inside 5 - 10 s
  localparam int unsigned FAULT_FLASH_S   = 17;  // Inside 15 - 20 s
  localparam int unsigned NODE_OPERATION_READY_LAMP_S     = 5;   // Node green lamp after power-on
  localparam int unsigned BLINK_HALF_MS   = 250;
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned SEC_W           = 6;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SLS_ALM_NONE, SLS_ALM_ERROR, SLS_ALM_CRIT} sls_alarm_e;

  typedef struct packed {
    logic       ready;
    logic       boot_done;
    logic       boot_error;
    sls_alarm_e alarm;
    logic       wire_rx_data;
    logic       control_station;
    logic       peer_present;
    logic       fiber_carrier;
    logic       fiber_rx_data;
    logic       net_tx;
    logic       on_battery;
    logic       charging;
  } sls_flags_s;

  typedef struct packed {
    logic front_operation_ready_lamp;
    logic front_alarm;
    logic wire_link_activity_lamp;
    logic net_data;
    logic power;
    logic boot;
    logic fault;
    logic operation_ready_lamp;
    logic fiber_line_activity_lamp;
    logic node_operation_ready_lamp;
    logic battery_source_lamp;
    logic charge;
  } sls_lamps_s;

  localparam int unsigned FLAGS_W = $bits(sls_flags_s);

endpackage

//--- rtl/sls_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sls_sync
  import sls_pkg::*;
#(
  parameter int unsigned W = 1
)(
  input  wire logic         clk,   // System clock
  input  wire logic         rst_n, // Synchronised reset
  input  wire logic [W-1:0] din,   // Asynchronous inputs
  output logic      [W-1:0] dout   // Filtered level
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  wire  [W-1:0] agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q  <= din;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= (agree & s3_q) | (~agree & out_q);
    end
  end
  assign dout = out_q;
endmodule // sls_sync
`default_nettype wire

//--- rtl/sls_blink.sv
`timescale 1ns/1ps
`default_nettype none
module sls_blink
  import sls_pkg::*;
#(
  parameter int unsigned HALF_CYC = BLINK_HALF_CYC,
  parameter int unsigned SEC_CYC  = CLK_HZ
)(
  input  wire logic clk,      // System clock
  input  wire logic rst_n,    // Synchronised reset
  output logic      blink,    // Shared flash phase
  output logic      sec_tick  // One pulse per second
);
  localparam int unsigned HW = $clog2(HALF_CYC + 1);
  localparam int unsigned SW = $clog2(SEC_CYC + 1);
  if (HALF_CYC < 2 || SEC_CYC < 2)
  begin : g_bad_counts
    $error("sls_blink: counts too small");
  end

  logic [HW-1:0] half_q;
  logic [SW-1:0] sec_q;
  logic          blink_q, tick_q;
  wire           half_end = (half_q == HW'(HALF_CYC - 1));
  wire           sec_end  = (sec_q == SW'(SEC_CYC - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_q  <= '0;
      sec_q   <= '0;
      blink_q <= 1'b0;
      tick_q  <= 1'b0;
    end
    else
    begin
      half_q  <= half_end ? '0 : half_q + HW'(1);
      blink_q <= blink_q ^ half_end;
      sec_q   <= sec_end ? '0 : sec_q + SW'(1);
      tick_q  <= sec_end;
    end
  end
  assign blink    = blink_q;
  assign sec_tick = tick_q;
endmodule // sls_blink
`default_nettype wire

//--- rtl/sls_top.sv
//Behaviour
//- Front amber lamp lights about 15 s after power-on, steady when ready.
//- Front red lamp flashes for error alarm, steady for critical alarm.
//- Wire link lamp flashes on received data with control station and peer present, steady otherwise.
//- Blue lamp lit while wire network transmits data.
//- Yellow power lamp steady whenever power is present.
//- Boot lamp steady 10-15 s, flashes 5-10 s, then off or on by error.
//- Fault lamp flashes 15-20 s after power-on, then follows alarm severity.
//- Control board green lamp steady when unit is ready.
//- Fiber lamp flashes on fiber data with carrier, steady with idle carrier.
//- Node green lamp on 5 s, dark during boot, steady once ready.
//- Battery lamp steady while battery is the power source.
//- Charge lamp steady while the battery charges.
`timescale 1ns/1ps
`default_nettype none
module sls_top
  import sls_pkg::*;
#(
  parameter int unsigned SEC_CYC  = CLK_HZ,        // Cycles per second
  parameter int unsigned HALF_CYC = BLINK_HALF_CYC // Cycles per blink half period
)(
  input  wire logic       sys_clk, // 50 MHz clock
  input  wire logic       arst_n,  // Async power-on reset
  input  wire sls_flags_s flags,   // Asynchronous status flags
  output sls_lamps_s      lamps    // Lamp drives, active high
);
  // ------------------------------------------------------------
  // Reset and input synchronisation
  // ------------------------------------------------------------
  logic rst1_q, rst2_q;
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst1_q <= 1'b0;
      rst2_q <= 1'b0;
    end
    else
    begin
      rst1_q <= 1'b1;
      rst2_q <= rst1_q;
    end
  end
  wire rst_n = rst2_q;

  logic [FLAGS_W-1:0] fsync;
  sls_sync #(.W(FLAGS_W)) u_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .din   (flags),
    .dout  (fsync)
  );
  sls_flags_s f;
  assign f = sls_flags_s'(fsync);

  logic blink, sec_tick;
  sls_blink #(.HALF_CYC(HALF_CYC), .SEC_CYC(SEC_CYC)) u_blink (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .blink    (blink),
    .sec_tick (sec_tick)
  );

  // ------------------------------------------------------------
  // Seconds since power-on, saturating
  // ------------------------------------------------------------
  logic [SEC_W-1:0] sec_q;
  wire              sec_sat = &sec_q;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      sec_q <= '0;
    else if (sec_tick && !sec_sat)
      sec_q <= sec_q + SEC_W'(1);
  end

  localparam logic [SEC_W-1:0] T_OPERATION_READY_LAMP  = SEC_W'(OPERATION_READY_LAMP_DELAY_S);
  localparam logic [SEC_W-1:0] T_BOOT1 = SEC_W'(BOOT_STEADY_S);
  localparam logic [SEC_W-1:0] T_BOOT2 = SEC_W'(BOOT_STEADY_S + BOOT_FLASH_S);
  localparam logic [SEC_W-1:0] T_FAULT = SEC_W'(FAULT_FLASH_S);
  localparam logic [SEC_W-1:0] T_NODE  = SEC_W'(NODE_OPERATION_READY_LAMP_S);

  // Boot lamp sequence runs on elapsed seconds alone; boot_done is not used
  typedef enum logic [1:0] {SLS_B_STEADY, SLS_B_FLASH, SLS_B_END} sls_boot_e;
  sls_boot_e boot_q, boot_d;
  always_comb
  begin
    boot_d = boot_q;
    case (boot_q)
      SLS_B_STEADY: if (sec_q >= T_BOOT1) boot_d = SLS_B_FLASH;
      SLS_B_FLASH:  if (sec_q >= T_BOOT2) boot_d = SLS_B_END;
      SLS_B_END:    boot_d = SLS_B_END;
      default:      boot_d = SLS_B_STEADY;
    endcase
  end

  // ------------------------------------------------------------
  // Lamp decode
  // ------------------------------------------------------------
  function automatic logic sev_lamp(input sls_alarm_e a, input logic bl);
    sev_lamp = (a == SLS_ALM_CRIT) | ((a == SLS_ALM_ERROR) & bl);
  endfunction

  wire front_operation_ready_lamp_w = (sec_q >= T_OPERATION_READY_LAMP) & f.ready;
  wire front_alm_w  = sev_lamp(f.alarm, blink);
  wire wire_idle    = !f.control_station | !f.peer_present;
  wire wire_lamp_w  = (f.wire_rx_data && !wire_idle) ? blink : 1'b1;
  wire boot_w       = (boot_q == SLS_B_STEADY) ? 1'b1 :
                      (boot_q == SLS_B_FLASH)  ? blink : f.boot_error;
  wire fault_w      = (sec_q < T_FAULT) ? blink : sev_lamp(f.alarm, blink);
  // Data without a carrier is treated as noise: the lamp stays dark
  wire fiber_data   = f.fiber_rx_data & f.fiber_carrier;
  wire fiber_w      = fiber_data ? blink : f.fiber_carrier;
  wire node_operation_ready_lamp_w  = (sec_q < T_NODE) | (boot_q == SLS_B_END & f.ready);

  sls_lamps_s lamps_d, lamps_q;
  always_comb
  begin
    lamps_d.front_operation_ready_lamp               = front_operation_ready_lamp_w;
    lamps_d.front_alarm              = front_alm_w;
    lamps_d.wire_link_activity_lamp  = wire_lamp_w;
    lamps_d.net_data                 = f.net_tx;
    lamps_d.power                    = 1'b1;
    lamps_d.boot                     = boot_w;
    lamps_d.fault                    = fault_w;
    lamps_d.operation_ready_lamp     = f.ready;
    lamps_d.fiber_line_activity_lamp = fiber_w;
    lamps_d.node_operation_ready_lamp                = node_operation_ready_lamp_w;
    lamps_d.battery_source_lamp      = f.on_battery;
    lamps_d.charge                   = f.charging;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_q  <= SLS_B_STEADY;
      lamps_q <= '0;
    end
    else
    begin
      boot_q  <= boot_d;
      lamps_q <= lamps_d;
    end
  end
  assign lamps = lamps_q;
endmodule // sls_top
`default_nettype wire

//--- sim/sls_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sls_checker
  import sls_pkg::*;
#(
  parameter int unsigned SEC_CYC = CLK_HZ
)(
  input wire logic       sys_clk, // System clock
  input wire logic       arst_n,  // Power-on reset
  input wire sls_flags_s flags,   // Status flags
  input wire sls_lamps_s lamps    // Lamp drives
);
  logic [15:0] cnt_q;
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
      cnt_q <= 16'h0;
    else if (cnt_q != 16'hFFFF)
      cnt_q <= cnt_q + 16'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Eight quiet cycles cover the input filter and lamp register
  power_lit_a: assert property (cnt_q > 16'h8 |-> lamps.power)
    else $error("power lamp dark");
  net_data_a: assert property ((cnt_q > 16'h10 && $stable(flags.net_tx))[*8]
    |-> lamps.net_data == flags.net_tx) else $error("data lamp wrong");
  battery_source_lamp_lamp_a: assert property ((cnt_q > 16'h10 && $stable(flags.on_battery))[*8]
    |-> lamps.battery_source_lamp == flags.on_battery) else $error("battery lamp wrong");
  crit_alarm_a: assert property ((cnt_q > 16'h10 && flags.alarm == SLS_ALM_CRIT)[*8]
    |-> lamps.front_alarm) else $error("critical alarm dark");
  no_alarm_a: assert property ((cnt_q > 16'h10 && flags.alarm == SLS_ALM_NONE)[*8]
    |-> !lamps.front_alarm) else $error("alarm lamp lit");
  operation_ready_lamp_early_a: assert property (cnt_q < 14 * SEC_CYC |-> !lamps.front_operation_ready_lamp)
    else $error("operation lamp early");
  wire_steady_a: assert property ((cnt_q > 16'h10 && !flags.control_station)[*8]
    |-> lamps.wire_link_activity_lamp) else $error("wire lamp dark");
  fiber_dark_a: assert property ((cnt_q > 16'h10 && !flags.fiber_carrier)[*8]
    |-> !lamps.fiber_line_activity_lamp) else $error("fiber lamp lit");
  boot_steady_a: assert property (cnt_q inside {[8:9 * SEC_CYC]} |-> lamps.boot)
    else $error("boot lamp dark");
  node_dark_a: assert property (cnt_q inside {[7 * SEC_CYC:10 * SEC_CYC]}
    |-> !lamps.node_operation_ready_lamp) else $error("node lamp lit in boot");
endmodule // sls_checker
`default_nettype wire

//--- sim/sls_lamp_viewer.sv
`timescale 1ns/1ps
`default_nettype none
module sls_lamp_viewer
  import sls_pkg::*;
(
  input  wire logic       clk,      // Sample clock
  input  wire logic       clr,      // Start a new look
  input  wire sls_lamps_s lamps,    // Lamp drives
  output sls_lamps_s      seen_on,  // Lamps seen lit
  output sls_lamps_s      seen_off  // Lamps seen dark
);
  // A flashing lamp shows up as seen both lit and dark in one look
  always_ff @(posedge clk)
  begin
    seen_on  <= clr ? '0 : seen_on | lamps;
    seen_off <= clr ? '0 : seen_off | ~lamps;
  end
endmodule // sls_lamp_viewer
`default_nettype wire

//--- sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sls_pkg::*;
;
  typedef struct packed {sls_flags_s f; sls_lamps_s st; sls_lamps_s fl;} sls_row_s;
  logic       sys_clk = 1'b0;
  logic       arst_n  = 1'b0;
  logic       clr     = 1'b1;
  sls_flags_s flags   = '0;
  sls_lamps_s lamps, seen_on, seen_off;
  int         fails = 0;
  int         check_count = 0;
  sls_row_s   rows [4] = '{{13'h1877, 12'hB9F, 12'h000}, {13'h1DF8, 12'h8D4, 12'h628},
                           {13'h0AA8, 12'h6A0, 12'h000}, {13'h18D8, 12'hA94, 12'h008}};
  always #10 sys_clk = ~sys_clk;
  // Short second and blink so the whole power-up fits in a few hundred cycles
  sls_top #(.SEC_CYC(20), .HALF_CYC(4)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
    .flags(flags), .lamps(lamps));
  sls_lamp_viewer view (.clk(sys_clk), .clr(clr), .lamps(lamps), .seen_on(seen_on),
    .seen_off(seen_off));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic look(input int n, input sls_lamps_s st, input sls_lamps_s fl);
    repeat (8) @(negedge sys_clk);
    clr = 1'b1;
    @(negedge sys_clk) clr = 1'b0;
    repeat (n) @(negedge sys_clk);
    check(seen_on, st | fl);
    check(seen_off, ~st);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Power-up phases, then steady-state rows, then a second reset
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(negedge sys_clk);
    check(lamps, 12'h000);
    arst_n = 1'b1;
    $display("reset test done");
    repeat (21) @(negedge sys_clk);
    look(40, 12'h2C4, 12'h020);
    repeat (71) @(negedge sys_clk);
    look(40, 12'h2C0, 12'h020);
    repeat (71) @(negedge sys_clk);
    look(40, 12'h280, 12'h060);
    $display("power-up test done");
    repeat (150) @(negedge sys_clk);
    foreach (rows[i])
    begin
      flags = rows[i].f;
      look(24, rows[i].st, rows[i].fl);
      $display("row %0d done", i);
    end
    arst_n = 1'b0;
    @(negedge sys_clk) check(lamps, 12'h000);
    arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    check(lamps, 12'h000);
    @(negedge sys_clk);
    check(lamps & 12'h080, 12'h080);
    $display("second reset test done");
    test_done();
  end
  initial
  begin
    #60000;
    fails++;
    test_done();
  end
endmodule // tb_top
bind sls_top sls_checker #(.SEC_CYC(SEC_CYC)) chk (.sys_clk(sys_clk), .arst_n(arst_n),
  .flags(flags), .lamps(lamps));
`default_nettype wire
